// File: hw/flsc_rx_count.sv
// Receive FIFO used-byte counter.
// Assumes frame and drain strobes on pclk, one cycle each.
module flsc_rx_count
  import flsc_pkg::*;
(
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Occupancy link
  flsc_occ_if.cnt   occ
);

  logic [15:0] used_q;
  logic [15:0] add_len;

  // Round frame length up to a whole 32-bit word
  assign add_len = (occ.frame_len + 16'h0003) & 16'hFFFC; // R2

  // Count up by frames, down by reads; both may land in one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      used_q <= FLSC_RX_OCC_RST; // R1
    end else begin
      used_q <= used_q + (occ.frame_add ? add_len : 16'h0000)
                - (occ.drain ? occ.drain_len : 16'h0000); // R2
    end
  end

  assign occ.used = used_q;

endmodule

// File: hw/flsc_top.sv
// APB register bank: FIFO levels, power management control, wake status and interrupts.
// Assumes FIFO, wake detector and resume sequencer pulses on pclk; status pins are async.
module flsc_top
  import flsc_pkg::*;
#(
  parameter int WDOG_CYCLES = 20000
)(
  // APB slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // FIFO level inputs
  input  wire logic        rx_frame_add,
  input  wire logic [15:0] rx_frame_len,
  input  wire logic        rx_drain,
  input  wire logic [15:0] rx_drain_len,
  input  wire logic [15:0] tx_free_bytes,
  // Resume and configuration events
  input  wire logic        resume_done,
  input  wire logic        resume_remote,
  input  wire logic        deconfigure,
  input  wire logic        normal_state,
  input  wire logic        config_done,
  input  wire logic        phy_clk_present,
  // Wake events from detectors
  input  wire logic        wake_energy_evt,
  input  wire logic        wake_lan_evt,
  input  wire logic        wake_frame_evt,
  input  wire logic        magic_packet_evt,
  input  wire logic        perfect_addr_evt,
  input  wire logic        broadcast_evt,
  // Outputs
  output logic [1:0]       suspend_sel,
  output logic [6:0]       wake_enables,
  output logic             irq
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [2:0] pin_s1_q;
  logic [2:0] pin_s2_q;

  // Level pins from other domains pass two flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_q <= 3'h0;
      pin_s2_q <= 3'h0;
    end else begin
      pin_s1_q <= {phy_clk_present, config_done, normal_state};
      pin_s2_q <= pin_s1_q;
    end
  end

  logic norm_s;
  logic cfg_s;
  logic phy_s;
  assign norm_s = pin_s2_q[0];
  assign cfg_s  = pin_s2_q[1];
  assign phy_s  = pin_s2_q[2];

  // ****************************************
  // APB decode
  // ****************************************
  logic wr_en;
  logic rd_en;
  logic hit;
  assign pready = 1'b1;
  assign wr_en  = psel & penable & pwrite;
  assign rd_en  = psel & penable & ~pwrite;
  assign hit    = (paddr == FLSC_RX_OCC_OFS) | (paddr == FLSC_TX_FREE_OFS) |
                  (paddr == FLSC_PM_CTL_OFS) | (paddr == FLSC_WAKE_OFS) |
                  (paddr == FLSC_IRQ_STS_OFS) | (paddr == FLSC_IRQ_CLR_OFS) |
                  (paddr == FLSC_IRQ_EN_OFS);
  assign pslverr = psel & penable & ~hit;

  logic pm_wr;
  logic wk_wr;
  logic ic_wr;
  logic ie_wr;
  assign pm_wr = wr_en & (paddr == FLSC_PM_CTL_OFS);
  assign wk_wr = wr_en & (paddr == FLSC_WAKE_OFS);
  assign ic_wr = wr_en & (paddr == FLSC_IRQ_CLR_OFS);
  assign ie_wr = wr_en & (paddr == FLSC_IRQ_EN_OFS);

  // ****************************************
  // Receive occupancy
  // ****************************************
  flsc_occ_if occ ();
  assign occ.frame_add = rx_frame_add;
  assign occ.frame_len = rx_frame_len;
  assign occ.drain     = rx_drain;
  assign occ.drain_len = rx_drain_len;

  flsc_rx_count u_rx_count (
    .pclk    (pclk),
    .presetn (presetn),
    .occ     (occ)
  );

  // ****************************************
  // Power management control
  // ****************************************
  logic       clr_sts_q;
  logic       clr_en_q;
  logic [1:0] susp_q;

  // Resume-clear controls, only written through byte lane 1
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clr_sts_q <= FLSC_CLR_STS_RST; // R6
      clr_en_q  <= FLSC_CLR_EN_RST;  // R7
    end else if (pm_wr && pstrb[1]) begin
      clr_sts_q <= pwdata[FLSC_CLR_STS_BIT];
      clr_en_q  <= pwdata[FLSC_CLR_EN_BIT];
    end
  end

  // Deconfiguration overrides any same-cycle write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      susp_q <= FLSC_SUSP_RST; // R12
    end else if (deconfigure) begin
      susp_q <= FLSC_SUSP_RST; // R13
    end else if (pm_wr && pstrb[0]) begin
      // Any value is stored; choosing only state two when unconfigured is software's job
      susp_q <= pwdata[FLSC_SUSP_LO +: 2]; // R12 R14
    end
  end
  assign suspend_sel = susp_q;

  // ****************************************
  // Ready flag with watchdog
  // ****************************************
  localparam int WD_W = $clog2(WDOG_CYCLES + 1);
  flsc_rdy_e         rdy_q;
  logic [WD_W-1:0]   wd_q;
  logic              ready;

  // Without PHY clocks the watchdog is the only way up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdy_q <= FLSC_RDY_WAIT;
      wd_q  <= '0;
    end else begin
      case (rdy_q)
        FLSC_RDY_WAIT: begin
          wd_q <= '0;
          if (norm_s && cfg_s) begin
            rdy_q <= phy_s ? FLSC_RDY_UP : FLSC_RDY_DOG; // R10 R11
          end
        end
        FLSC_RDY_DOG: begin
          if (!(norm_s && cfg_s)) begin
            rdy_q <= FLSC_RDY_WAIT;
          end else if (phy_s || wd_q == WD_W'(WDOG_CYCLES - 1)) begin
            rdy_q <= FLSC_RDY_UP; // R11
          end else begin
            wd_q <= wd_q + WD_W'(1);
          end
        end
        FLSC_RDY_UP: begin
          if (!(norm_s && cfg_s)) begin
            rdy_q <= FLSC_RDY_WAIT; // R10
          end
        end
        default: rdy_q <= FLSC_RDY_WAIT;
      endcase
    end
  end
  assign ready = (rdy_q == FLSC_RDY_UP); // R10

  // ****************************************
  // Wake status and enables
  // ****************************************
  // Status bits: 0 frame, 1 magic, 2 perfect addr, 3 broadcast, 4..5 cause
  logic [5:0] wsts_q;
  logic [5:0] wsts_set;
  logic       sts_clr;
  logic       en_clr;
  assign wsts_set = {wake_lan_evt, wake_energy_evt, broadcast_evt,
                     perfect_addr_evt, magic_packet_evt, wake_frame_evt}; // R15
  assign sts_clr  = resume_done & clr_sts_q;                 // R4 R6
  assign en_clr   = resume_done & resume_remote & clr_en_q;  // R7 R8

  // Set wins over write-one-clear and resume clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wsts_q <= 6'h00;
    end else begin
      wsts_q <= (wsts_q
                 & ~((wk_wr && pstrb[2]) ? pwdata[21:16] : 6'h00)
                 & ~(sts_clr ? 6'b10_1111 : 6'h00)) // R4 R5
                | wsts_set;
    end
  end

  // Enables: 0 frame, 1 magic, 2 perfect, 3 bcast, 4 unicast, 5 energy, 6 lan
  logic [6:0] wen_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wen_q <= 7'h00;
    end else if (wk_wr && pstrb[0]) begin
      wen_q <= pwdata[6:0];
    end else if (en_clr) begin
      // Only energy-detect and wake-on-LAN enables are dropped
      wen_q <= wen_q & 7'b001_1111; // R7 R9
    end
  end
  assign wake_enables = wen_q;

  // ****************************************
  // Interrupts
  // ****************************************
  // Events: 0 frame received, 1 resume done, 2 ready rose
  logic                     ready_d1_q;
  logic [FLSC_NUM_IRQ-1:0]  ists_q;
  logic [FLSC_NUM_IRQ-1:0]  ien_q;
  logic [FLSC_NUM_IRQ-1:0]  ievt;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_d1_q <= 1'b0;
    end else begin
      ready_d1_q <= ready;
    end
  end
  assign ievt = {ready & ~ready_d1_q, resume_done, rx_frame_add};

  // Sticky status; a new event beats a same-cycle clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ists_q <= '0;
    end else begin
      ists_q <= (ists_q & ~(ic_wr ? pwdata[FLSC_NUM_IRQ-1:0] : '0)) | ievt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ien_q <= '0;
    end else if (ie_wr) begin
      ien_q <= pwdata[FLSC_NUM_IRQ-1:0];
    end
  end
  assign irq = |(ists_q & ien_q);

  // ****************************************
  // Read data
  // ****************************************
  // Reserved bits and write-only registers read zero
  always_comb begin
    prdata = 32'h0000_0000;
    if (rd_en) begin
      case (paddr)
        FLSC_RX_OCC_OFS:  prdata = {16'h0000, occ.used};       // R1 R16
        FLSC_TX_FREE_OFS: prdata = {16'h0000, tx_free_bytes};  // R3 R16
        FLSC_PM_CTL_OFS:  prdata = {22'h0, clr_sts_q, clr_en_q, ready, susp_q, 5'h00}; // R16
        FLSC_WAKE_OFS:    prdata = {10'h0, wsts_q, 9'h0, wen_q};
        FLSC_IRQ_STS_OFS: prdata = {29'h0, ists_q};
        FLSC_IRQ_EN_OFS:  prdata = {29'h0, ien_q};
        default:          prdata = 32'h0000_0000;
      endcase
    end
  end

endmodule

// File: inc/flsc_occ_if.sv
// Interface carrying receive occupancy updates between the bank and its counter.
// Assumes both ends on pclk.
interface flsc_occ_if;
  logic        frame_add;
  logic [15:0] frame_len;
  logic        drain;
  logic [15:0] drain_len;
  logic [15:0] used;

  modport ctl (output frame_add, output frame_len, output drain, output drain_len,
               input used);
  modport cnt (input frame_add, input frame_len, input drain, input drain_len,
               output used);
endinterface

// File: inc/flsc_pkg.sv
// Constants, register map and types for the FIFO level and suspend control bank.
// Assumes an APB master on pclk and FIFO, wakeup and resume logic outside the block.
// What this block does
// R1: Receive FIFO used-byte count is a 16-bit read-only field, reset zero.
// R2: Each received frame adds its length rounded up to a whole word.
// R3: Transmit FIFO free-byte count is 16-bit read-only, reset 2000h; the block passes tx_free_bytes through with no reset value of its own.
// R4: Resume-clears-status bit set: resume end clears four wake received flags.
// R5: Resume-clears-status bit set: resume end also clears upper wake cause bit.
// R6: Resume-clears-status bit clear (reset): wake status kept after resume.
// R7: Resume-clears-enables bit set (reset): remote-wake resume end clears wake enables.
// R8: Host-initiated resume never clears any wake enable bits.
// R9: Unicast, perfect address, frame, magic, broadcast enables are never resume-cleared.
// R10: Ready flag set only in normal state with configuration done; resets zero.
// R11: Without PHY clocks ready stays low until the watchdog expires.
// R12: Two-bit suspend selection chooses suspend state zero to three, reset 10b.
// R13: Deconfiguration forces suspend selection back to 10b.
// R14: Software selects only suspend state two while unconfigured; the block stores any value written to the suspend field.
// R15: Wake cause bit 0 flags energy detect, bit 1 wake-on-LAN or good frame.
// R16: Reserved bits read zero; writes to read-only fields have no effect.
package flsc_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [11:0] FLSC_RX_OCC_OFS   = 12'h018;
  localparam logic [11:0] FLSC_TX_FREE_OFS  = 12'h01C;
  localparam logic [11:0] FLSC_PM_CTL_OFS   = 12'h020;
  localparam logic [11:0] FLSC_WAKE_OFS     = 12'h028;
  localparam logic [11:0] FLSC_IRQ_STS_OFS  = 12'h02C;
  localparam logic [11:0] FLSC_IRQ_CLR_OFS  = 12'h030;
  localparam logic [11:0] FLSC_IRQ_EN_OFS   = 12'h034;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int FLSC_CLR_STS_BIT  = 9;
  localparam int FLSC_CLR_EN_BIT   = 8;
  localparam int FLSC_READY_BIT    = 7;
  localparam int FLSC_SUSP_LO      = 5;
  localparam int FLSC_NUM_IRQ      = 3;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [15:0] FLSC_RX_OCC_RST  = 16'h0000;
  localparam logic [15:0] FLSC_TX_FREE_RST = 16'h2000;
  localparam logic [1:0]  FLSC_SUSP_RST    = 2'h2;
  localparam logic        FLSC_CLR_STS_RST = 1'b0;
  localparam logic        FLSC_CLR_EN_RST  = 1'b1;

  // Ready tracking states
  typedef enum logic [2:0] {
    FLSC_RDY_WAIT  = 3'b001,
    FLSC_RDY_UP    = 3'b010,
    FLSC_RDY_DOG   = 3'b100
  } flsc_rdy_e;

endpackage

// File: testbench/flsc_monitor.sv
// Concurrent checks on the FIFO level and suspend control bank ports.
// Assumes APB on pclk, presetn active low, bound to flsc_top below.
module flsc_monitor
  import flsc_pkg::*;
(
  // Clock, reset and APB
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // Events and outputs
  input wire logic [15:0] tx_free_bytes,
  input wire logic        resume_done,
  input wire logic        resume_remote,
  input wire logic        deconfigure,
  input wire logic        normal_state,
  input wire logic [1:0]  suspend_sel,
  input wire logic [6:0]  wake_enables
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Access phase decodes and slices fed to $past
  wire       acc    = psel && penable;
  wire       rd_pm  = acc && !pwrite && paddr == FLSC_PM_CTL_OFS;
  wire       wr_wk  = acc && pwrite && paddr == FLSC_WAKE_OFS;
  wire [1:0] wr_sus = pwdata[6:5];
  wire [4:0] kept   = wake_enables[4:0];
  // ****************************************
  // Sequences and properties
  // ****************************************
  // Sync stages need a few cycles before ready can drop
  sequence s_off5; (!normal_state)[*5]; endsequence
  sequence s_host; resume_done && !resume_remote && !wr_wk; endsequence
  property p_deconf; deconfigure |=> suspend_sel == 2'h2; endproperty
  property p_sus_wr;
    acc && pwrite && paddr == FLSC_PM_CTL_OFS && pstrb[0] && !deconfigure
      |=> suspend_sel == $past(wr_sus);
  endproperty
  property p_sus_rd; rd_pm |-> prdata[6:5] == suspend_sel; endproperty
  property p_ready; s_off5 ##0 rd_pm |-> !prdata[FLSC_READY_BIT]; endproperty
  property p_host; s_host |=> $stable(wake_enables); endproperty
  property p_remote; resume_done && resume_remote && !wr_wk |=> kept == $past(kept); endproperty
  property p_tx;
    acc && !pwrite && paddr == FLSC_TX_FREE_OFS |-> prdata == {16'h0000, tx_free_bytes};
  endproperty
  property p_rx_hi;
    acc && !pwrite && paddr == FLSC_RX_OCC_OFS |-> prdata[31:16] == 16'h0000;
  endproperty
  property p_unmap; acc && paddr == 12'h024 |-> pslverr; endproperty
  a_deconf: assert property (p_deconf) else $error("suspend not forced");
  a_sus_wr: assert property (p_sus_wr) else $error("suspend write lost");
  a_sus_rd: assert property (p_sus_rd) else $error("suspend readback");
  a_ready: assert property (p_ready) else $error("ready while not normal");
  a_host: assert property (p_host) else $error("host resume moved enables");
  a_remote: assert property (p_remote) else $error("excluded enable cleared");
  a_tx: assert property (p_tx) else $error("tx free read wrong");
  a_rx_hi: assert property (p_rx_hi) else $error("reserved bits set");
  a_unmap: assert property (p_unmap) else $error("no error on unmapped");
endmodule

bind flsc_top flsc_monitor u_mon (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pstrb, .prdata, .pslverr, .tx_free_bytes, .resume_done, .resume_remote, .deconfigure,
  .normal_state, .suspend_sel, .wake_enables);

// File: testbench/test_fifo_level_and_suspend_control.sv
// Self-checking bench for the FIFO level and suspend control bank.
// Assumes flsc_top with a short watchdog and an APB master held here.
module test_fifo_level_and_suspend_control
  import flsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // Design connections
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] rx_frame_len, rx_drain_len, tx_free_bytes;
  logic        rx_frame_add, rx_drain, resume_done, resume_remote, deconfigure;
  logic        normal_state, config_done, phy_clk_present;
  logic [5:0]  wk;
  logic [1:0]  suspend_sel;
  logic [3:0]  pstrb;
  logic [6:0]  wake_enables;
  int          n_errors = 0, compares = 0, cyc = 0;

  // Short watchdog keeps the no-clock case quick
  flsc_top #(.WDOG_CYCLES(8)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .rx_frame_add, .rx_frame_len, .rx_drain,
    .rx_drain_len, .tx_free_bytes, .resume_done, .resume_remote, .deconfigure, .normal_state,
    .config_done, .phy_clk_present, .wake_energy_evt(wk[4]), .wake_lan_evt(wk[5]),
    .wake_frame_evt(wk[0]), .magic_packet_evt(wk[1]), .perfect_addr_evt(wk[2]),
    .broadcast_evt(wk[3]), .suspend_sel, .wake_enables, .irq);

  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One APB transfer, held until pready is seen
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic res(input logic remote);
    @(posedge pclk) {resume_done, resume_remote} <= {1'b1, remote};
    @(posedge pclk) resume_done <= 1'b0;
  endtask
  task automatic final_report;
    $display("n_errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    rdc(FLSC_RX_OCC_OFS, 32'h0);
    rdc(FLSC_PM_CTL_OFS, 32'h140);
    tx_free_bytes <= 16'h1234;
    rdc(FLSC_TX_FREE_OFS, 32'h1234);
    rdc(12'h024, 32'h0);
    chk(err, 1'b1);
  endtask
  // Back-to-back frames of 5 and 8 bytes, then a drain and the interrupt path
  task automatic t_rx;
    @(posedge pclk) {rx_frame_add, rx_frame_len} <= {1'b1, 16'h5};
    @(posedge pclk) rx_frame_len <= 16'h8;
    @(posedge pclk) rx_frame_add <= 1'b0;
    apb(1'b1, FLSC_RX_OCC_OFS, 32'hFFFF);
    rdc(FLSC_RX_OCC_OFS, 32'h10);
    @(posedge pclk) {rx_drain, rx_drain_len} <= {1'b1, 16'h6};
    @(posedge pclk) rx_drain <= 1'b0;
    rdc(FLSC_RX_OCC_OFS, 32'hA);
    rdc(FLSC_IRQ_STS_OFS, 32'h1);
    apb(1'b1, FLSC_IRQ_EN_OFS, 32'h1);
    @(negedge pclk) chk(irq, 1'b1);
    apb(1'b1, FLSC_IRQ_EN_OFS, 32'h0);
    @(negedge pclk) chk(irq, 1'b0);
    apb(1'b1, FLSC_IRQ_CLR_OFS, 32'h1);
    rdc(FLSC_IRQ_STS_OFS, 32'h0);
  endtask
  task automatic t_susp;
    // Runs configured and ready, so every suspend state is a legal choice
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, FLSC_PM_CTL_OFS, 32'h100 | (i << 5));
      rdc(FLSC_PM_CTL_OFS, 32'h180 | (i << 5));
    end
    // Lane 0 only: suspend field moves, resume-clear controls hold
    @(posedge pclk) pstrb <= 4'h1;
    apb(1'b1, FLSC_PM_CTL_OFS, 32'h0);
    pstrb <= 4'hF;
    rdc(FLSC_PM_CTL_OFS, 32'h180);
    @(posedge pclk) deconfigure <= 1'b1;
    @(posedge pclk) deconfigure <= 1'b0;
    rdc(FLSC_PM_CTL_OFS, 32'h1C0);
  endtask
  task automatic t_ready;
    @(posedge pclk) {normal_state, config_done, phy_clk_present} <= 3'b111;
    repeat (6) @(posedge pclk);
    rdc(FLSC_PM_CTL_OFS, 32'h1C0);
    @(posedge pclk) {normal_state, phy_clk_present} <= 2'b00;
    repeat (5) @(posedge pclk);
    rdc(FLSC_PM_CTL_OFS, 32'h140);
    @(posedge pclk) normal_state <= 1'b1;
    // Two sync stages, one step into the watchdog, then 8 counted cycles
    repeat (8) @(posedge pclk);
    rdc(FLSC_PM_CTL_OFS, 32'h140);
    rdc(FLSC_PM_CTL_OFS, 32'h1C0);
  endtask
  task automatic t_wake;
    apb(1'b1, FLSC_WAKE_OFS, 32'h7F);
    @(posedge pclk) wk <= 6'h3F;
    @(posedge pclk) wk <= 6'h00;
    res(1'b0);
    rdc(FLSC_WAKE_OFS, 32'h3F007F);
    res(1'b1);
    rdc(FLSC_WAKE_OFS, 32'h3F001F);
    apb(1'b1, FLSC_PM_CTL_OFS, 32'h240);
    apb(1'b1, FLSC_WAKE_OFS, 32'h7F);
    res(1'b1);
    rdc(FLSC_WAKE_OFS, 32'h10007F);
    // Write one clears the remaining energy-detect cause bit
    apb(1'b1, FLSC_WAKE_OFS, 32'h10007F);
    rdc(FLSC_WAKE_OFS, 32'h7F);
    // Ready rose and resumes completed since the last clear
    rdc(FLSC_IRQ_STS_OFS, 32'h6);
  endtask

  // Clock and hang guard
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors++;
      final_report();
    end
  end
  // Main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata, rx_frame_add, rx_drain, wk} = '0;
    {resume_done, resume_remote, deconfigure, rx_frame_len, rx_drain_len} = '0;
    {normal_state, config_done, phy_clk_present} = '0;
    tx_free_bytes = 16'h2000;
    pstrb = 4'hF;
    presetn = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rdc(FLSC_TX_FREE_OFS, 32'h2000);
    t_reset();
    t_rx();
    t_ready();
    t_susp();
    t_wake();
    final_report();
  end
endmodule
